// file: pkg/fspwm_map.svh
// Register map, field positions, reset values and timing counts
//****************************************************************
// Overview of operation
// RL1: Reset drives both fan outputs low, enabled.
// RL2: Override bit forces output continuously high.
// RL3: Duty zero without override keeps output low.
// RL4: Duty 63 gives 63/64 high, 1/64 low.
// RL5: High fraction equals duty level over 64.
// RL6: Fan register: override 0, duty 6:1, select 7.
// RL7: Source and select pick the base frequency.
// RL8: Multiplier bit doubles the selected frequency.
// RL9: Shared register multipliers sit at bits 2, 3.
// RL10: Shared register source selects at bits 0, 1.
// RL11: Shared register tachometer divisors, bits 5:4, 7:6.
// RL12: Period is 64 slots at 64x output rate.
// RL13: New duty and frequency settings take effect at period boundary; the override bit is applied on the next clock.
//****************************************************************
`ifndef FSPWM_MAP_SVH
`define FSPWM_MAP_SVH

// Register indices; byte address is four times the index
`define FSPWM_IDX_FAN_A       12'h056
`define FSPWM_IDX_FAN_B       12'h057
`define FSPWM_IDX_CTRL        12'h058
`define FSPWM_IDX_STATUS      12'h059
`define FSPWM_ADDR_FAN_A      (`FSPWM_IDX_FAN_A * 12'h004)
`define FSPWM_ADDR_FAN_B      (`FSPWM_IDX_FAN_B * 12'h004)
`define FSPWM_ADDR_CTRL       (`FSPWM_IDX_CTRL * 12'h004)
`define FSPWM_ADDR_STATUS     (`FSPWM_IDX_STATUS * 12'h004)

// Fan drive register fields
`define FSPWM_OVR_BIT         0
`define FSPWM_DUTY_LSB        1
`define FSPWM_DUTY_MSB        6
`define FSPWM_FSEL_BIT        7
`define FSPWM_FAN_RESET       8'h00

// Shared control register fields, fan a then fan b
`define FSPWM_SRC_A_BIT       0
`define FSPWM_SRC_B_BIT       1
`define FSPWM_MUL_A_BIT       2
`define FSPWM_MUL_B_BIT       3
`define FSPWM_TDIV_A_LSB      4
`define FSPWM_TDIV_B_LSB      6
// Tachometer divisor defaults to divide by 2 (code 01) on both fans
`define FSPWM_CTRL_RESET      8'h50

// Timing: clock and output frequencies in millihertz
`define FSPWM_CLK_MHZ         64'd50000000000
`define FSPWM_F_SRC0_SEL0_MHZ 64'd15625000
`define FSPWM_F_SRC0_SEL1_MHZ 64'd23438000
`define FSPWM_F_SRC1_SEL0_MHZ 64'd40000
`define FSPWM_F_SRC1_SEL1_MHZ 64'd60000
`define FSPWM_SLOTS           64'd64
`define FSPWM_DIV(f, m)  (`FSPWM_CLK_MHZ / (`FSPWM_SLOTS * (f) * (m)))

`endif

// file: pkg/fspwm_pkg.sv
// Types shared by the fan speed modulator
package fspwm_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } fspwm_apb_req_type;

    typedef struct packed {
        logic [19:0] presc;
        logic [5:0]  slot;
        logic [5:0]  duty;
        logic [19:0] div;
        logic        tick;
        logic        out;
    } fspwm_chan_type;

    typedef struct packed {
        logic [1:0][7:0]       drive;
        logic [7:0]            ctrl;
        logic [31:0]           rdata;
        fspwm_chan_type [1:0]  chan;
    } fspwm_state_type;

endpackage : fspwm_pkg

// file: design/fspwm_top.sv
// Two-channel fan speed pulse width modulator with APB registers
`include "fspwm_map.svh"

module fspwm_top
    import fspwm_pkg::*;
#(
    parameter logic [19:0] SLOW_SEL0_DIV =
        20'(`FSPWM_DIV(`FSPWM_F_SRC1_SEL0_MHZ, 64'd1)),
    parameter logic [19:0] SLOW_SEL1_DIV =
        20'(`FSPWM_DIV(`FSPWM_F_SRC1_SEL1_MHZ, 64'd1)),
    parameter logic [19:0] SLOW_SEL0_DIV_X2 =
        20'(`FSPWM_DIV(`FSPWM_F_SRC1_SEL0_MHZ, 64'd2)),
    parameter logic [19:0] SLOW_SEL1_DIV_X2 =
        20'(`FSPWM_DIV(`FSPWM_F_SRC1_SEL1_MHZ, 64'd2))
) (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             FAN_SPEED_OUT_A,
    output logic             FAN_SPEED_OUT_A_OE,
    output logic             FAN_SPEED_OUT_B,
    output logic             FAN_SPEED_OUT_B_OE
);

    //************************************************************
    // Frequency dividers
    //************************************************************
    // Fast rates are short enough to stay fixed; the slow ones are
    // parameters so that a simulation can shorten them.
    localparam logic [19:0] FAST_SEL0_DIV =
        20'(`FSPWM_DIV(`FSPWM_F_SRC0_SEL0_MHZ, 64'd1));
    localparam logic [19:0] FAST_SEL1_DIV =
        20'(`FSPWM_DIV(`FSPWM_F_SRC0_SEL1_MHZ, 64'd1));
    localparam logic [19:0] FAST_SEL0_DIV_X2 =
        20'(`FSPWM_DIV(`FSPWM_F_SRC0_SEL0_MHZ, 64'd2));
    localparam logic [19:0] FAST_SEL1_DIV_X2 =
        20'(`FSPWM_DIV(`FSPWM_F_SRC0_SEL1_MHZ, 64'd2));

    function automatic logic [19:0] pick_div(
        input logic src,
        input logic fsel,
        input logic mul
    );
        logic [19:0] d;
        d = FAST_SEL0_DIV;
        case ({src, fsel, mul})                                // RL7
            3'h0:    d = FAST_SEL0_DIV;
            3'h1:    d = FAST_SEL0_DIV_X2;                     // RL8
            3'h2:    d = FAST_SEL1_DIV;
            3'h3:    d = FAST_SEL1_DIV_X2;                     // RL8
            3'h4:    d = SLOW_SEL0_DIV;
            3'h5:    d = SLOW_SEL0_DIV_X2;                     // RL8
            3'h6:    d = SLOW_SEL1_DIV;
            3'h7:    d = SLOW_SEL1_DIV_X2;                     // RL8
            default: d = FAST_SEL0_DIV;
        endcase
        return d;
    endfunction

    //************************************************************
    // State
    //************************************************************
    fspwm_apb_req_type req;
    fspwm_state_type   s_reg;
    fspwm_state_type   s_next;
    logic              hit_fan_a;
    logic              hit_fan_b;
    logic              hit_ctrl;
    logic              hit_status;
    logic              mapped;
    logic [1:0]        src_sel;
    logic [1:0]        mul_sel;

    assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE,
                   paddr: PADDR, pwdata: PWDATA};

    assign hit_fan_a  = (req.paddr == `FSPWM_ADDR_FAN_A);
    assign hit_fan_b  = (req.paddr == `FSPWM_ADDR_FAN_B);
    assign hit_ctrl   = (req.paddr == `FSPWM_ADDR_CTRL);
    assign hit_status = (req.paddr == `FSPWM_ADDR_STATUS);
    assign mapped     = hit_fan_a | hit_fan_b | hit_ctrl | hit_status;

    assign src_sel = {s_reg.ctrl[`FSPWM_SRC_B_BIT],
                      s_reg.ctrl[`FSPWM_SRC_A_BIT]};          // RL10
    assign mul_sel = {s_reg.ctrl[`FSPWM_MUL_B_BIT],
                      s_reg.ctrl[`FSPWM_MUL_A_BIT]};          // RL9

    //************************************************************
    // Next state
    //************************************************************
    always_comb begin
        logic [19:0] new_div;
        logic        ovr;
        new_div = '0;
        ovr     = 1'b0;
        s_next  = s_reg;

        // Register bus: read data is taken in the setup cycle so that
        // it comes from a flip-flop during the access cycle.
        if (req.psel && !req.penable) begin
            s_next.rdata = '0;
            if (hit_fan_a) begin
                s_next.rdata[7:0] = s_reg.drive[0];
            end else if (hit_fan_b) begin
                s_next.rdata[7:0] = s_reg.drive[1];
            end else if (hit_ctrl) begin
                s_next.rdata[7:0] = s_reg.ctrl;                // RL11
            end else if (hit_status) begin
                s_next.rdata[1:0] = {s_reg.chan[1].out,
                                     s_reg.chan[0].out};
            end
        end
        if (req.psel && req.penable && req.pwrite) begin
            if (hit_fan_a) begin
                s_next.drive[0] = req.pwdata[7:0];             // RL6
            end else if (hit_fan_b) begin
                s_next.drive[1] = req.pwdata[7:0];             // RL6
            end else if (hit_ctrl) begin
                s_next.ctrl = req.pwdata[7:0];         // RL9 RL10 RL11
            end
        end

        // Per-fan slot timer and output
        for (int i = 0; i < 2; i++) begin
            ovr = s_reg.drive[i][`FSPWM_OVR_BIT];
            new_div = pick_div(src_sel[i],
                               s_reg.drive[i][`FSPWM_FSEL_BIT],
                               mul_sel[i]);
            s_next.chan[i].tick = 1'b0;
            if (s_reg.chan[i].presc >= s_reg.chan[i].div - 20'h00001) begin
                s_next.chan[i].presc = '0;                     // RL12
                s_next.chan[i].tick  = 1'b1;
                s_next.chan[i].slot  = s_reg.chan[i].slot + 6'h01;
                // Duty and divider load only as a period ends, so a write to
                // them never cuts a pulse short.
                if (s_reg.chan[i].slot == 6'h3F) begin         // RL13
                    s_next.chan[i].duty =
                        s_reg.drive[i][`FSPWM_DUTY_MSB:`FSPWM_DUTY_LSB];
                    s_next.chan[i].div = new_div;
                end
            end else begin
                s_next.chan[i].presc = s_reg.chan[i].presc + 20'h00001;
            end
            // Slots below duty are high; duty 0 never high, 63 misses one
            if (ovr) begin
                s_next.chan[i].out = 1'b1;                     // RL2
            end else begin
                s_next.chan[i].out =                   // RL3 RL4 RL5
                    (s_next.chan[i].slot < s_next.chan[i].duty);
            end
        end
    end

    //************************************************************
    // Registers
    //************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            s_reg          <= '0;                              // RL1
            s_reg.drive[0] <= `FSPWM_FAN_RESET;
            s_reg.drive[1] <= `FSPWM_FAN_RESET;
            s_reg.ctrl     <= `FSPWM_CTRL_RESET;
            s_reg.chan[0].div <= FAST_SEL0_DIV;
            s_reg.chan[1].div <= FAST_SEL0_DIV;
        end else begin
            s_reg <= s_next;
        end
    end

    //************************************************************
    // Outputs
    //************************************************************
    assign PRDATA             = s_reg.rdata;
    assign PREADY             = PSEL & PENABLE;
    assign PSLVERR            = PSEL & PENABLE & ~mapped;
    assign FAN_SPEED_OUT_A    = s_reg.chan[0].out;             // RL1
    assign FAN_SPEED_OUT_B    = s_reg.chan[1].out;             // RL1
    // Pins are always outputs in this function
    assign FAN_SPEED_OUT_A_OE = 1'b1;                          // RL1
    assign FAN_SPEED_OUT_B_OE = 1'b1;                          // RL1

    //************************************************************
    // Assertions
    //************************************************************
    property p_reset_low;
        @(posedge CORE_CLK)
        SYS_RST |=> !FAN_SPEED_OUT_A && !FAN_SPEED_OUT_B;
    endproperty
    a_reset_low: assert property (p_reset_low)                 // RL1
        else $error("fan outputs not low after reset");

    property p_override_high;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_reg.drive[0][`FSPWM_OVR_BIT] [*2] |-> FAN_SPEED_OUT_A;
    endproperty
    a_override_high: assert property (p_override_high)         // RL2
        else $error("override set but fan a output low");

    property p_zero_duty_low;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s_reg.chan[1].duty == 6'h00)
            && !$past(s_reg.drive[1][`FSPWM_OVR_BIT])
            |-> !FAN_SPEED_OUT_B;
    endproperty
    a_zero_duty_low: assert property (p_zero_duty_low)         // RL3
        else $error("fan b pulses with zero duty");

    property p_max_duty_last_slot;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s_reg.chan[0].duty == 6'h3F) && (s_reg.chan[0].slot == 6'h3F)
            && !$past(s_reg.drive[0][`FSPWM_OVR_BIT])
            |-> !FAN_SPEED_OUT_A;
    endproperty
    a_max_duty_last_slot: assert property (p_max_duty_last_slot) // RL4
        else $error("fan a high in last slot at full duty");

    property p_first_slot_high;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s_reg.chan[0].duty != 6'h00) && (s_reg.chan[0].slot == 6'h00)
            |-> FAN_SPEED_OUT_A;
    endproperty
    a_first_slot_high: assert property (p_first_slot_high)     // RL5
        else $error("fan a low in first slot with nonzero duty");

    property p_write_fan_a;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        PSEL && PENABLE && PWRITE && hit_fan_a
            |=> s_reg.drive[0] == $past(PWDATA[7:0]);
    endproperty
    a_write_fan_a: assert property (p_write_fan_a)             // RL6
        else $error("fan a register write lost");

    property p_fast_tick_spacing;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        s_reg.chan[0].tick && (s_reg.chan[0].div == FAST_SEL0_DIV)
            |=> !s_reg.chan[0].tick [*8];
    endproperty
    a_fast_tick_spacing: assert property (p_fast_tick_spacing) // RL7
        else $error("fan a slot ticks too close");

    property p_ctrl_read;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        PSEL && !PENABLE && hit_ctrl
            |=> PRDATA == {24'h000000, $past(s_reg.ctrl)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)            // RL9 RL10
        else $error("shared control read mismatch");

    property p_slot_on_tick;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s_reg.chan[1].slot != $past(s_reg.chan[1].slot))
            |-> s_reg.chan[1].tick;
    endproperty
    a_slot_on_tick: assert property (p_slot_on_tick)           // RL12
        else $error("fan b slot moved without tick");

    property p_load_at_boundary;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (s_reg.chan[0].duty != $past(s_reg.chan[0].duty))
            |-> s_reg.chan[0].tick && (s_reg.chan[0].slot == 6'h00);
    endproperty
    a_load_at_boundary: assert property (p_load_at_boundary)   // RL13
        else $error("fan a duty changed inside a period");

endmodule // fspwm_top

// file: testbench/fspwm_fan_model.sv
// Fan motor drive model that measures period and pulse width of one output
module fspwm_fan_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        drive,
    input  wire logic        drive_oe,
    output logic      [31:0] period,
    output logic      [31:0] width,
    output logic      [31:0] rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        lvl;
    logic        prev;
    logic [31:0] cnt;
    logic [31:0] hcnt;
    // Undriven pin reads low through the motor driver's pull-down
    assign lvl = drive_oe ? drive : 1'b0;
    always_ff @(posedge clk) begin
        if (rst) begin
            prev   <= 1'b0;
            cnt    <= '0;
            hcnt   <= '0;
            period <= '0;
            width  <= '0;
            rises  <= '0;
        end else begin
            prev <= lvl;
            cnt  <= cnt + 32'd1;
            if (lvl && !prev) begin
                period <= cnt;
                rises  <= rises + 32'd1;
                cnt    <= 32'd1;
                hcnt   <= 32'd1;
            end else if (lvl) begin
                hcnt <= hcnt + 32'd1;
            end
            // Width is only known once the pulse has ended
            if (!lvl && prev) begin
                width <= hcnt;
            end
        end
    end
endmodule // fspwm_fan_model

// file: testbench/fan_speed_pwm_control_tb.sv
// Self-checking testbench for the fan speed modulator
`include "fspwm_map.svh"

module fan_speed_pwm_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Slot divider cycles indexed by {source, multiplier, select}
    localparam int DV [8] = '{50, 33, 25, 16, 20, 14, 10, 7};
    logic        core_clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        out_a;
    logic        oe_a;
    logic        out_b;
    logic        oe_b;
    logic [31:0] per_a;
    logic [31:0] wid_a;
    logic [31:0] ris_a;
    logic [31:0] per_b;
    logic [31:0] wid_b;
    logic [31:0] ris_b;
    int          n_errors = 0;
    int          compares = 0;

    fspwm_top #(.SLOW_SEL0_DIV(20'd20), .SLOW_SEL1_DIV(20'd14),
        .SLOW_SEL0_DIV_X2(20'd10), .SLOW_SEL1_DIV_X2(20'd7)) dut (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FAN_SPEED_OUT_A(out_a),
        .FAN_SPEED_OUT_A_OE(oe_a), .FAN_SPEED_OUT_B(out_b),
        .FAN_SPEED_OUT_B_OE(oe_b));
    fspwm_fan_model fan_a (.clk(core_clk), .rst(sys_rst), .drive(out_a),
        .drive_oe(oe_a), .period(per_a), .width(wid_a), .rises(ris_a));
    fspwm_fan_model fan_b (.clk(core_clk), .rst(sys_rst), .drive(out_b),
        .drive_oe(oe_b), .period(per_b), .width(wid_b), .rises(ris_b));

    always #10 core_clk = ~core_clk;

    //****************************************************************
    // Bus and compare tasks
    //****************************************************************
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check("pready", {31'h0, pready}, 32'h1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0, r, e);
        check("rdata", r, exp);
        check("pslverr", {31'h0, e}, 32'h0);
    endtask

    // Waits until both fans have begun n more periods
    task automatic wait_rises(input int n);
        logic [31:0] a0;
        logic [31:0] b0;
        int          k;
        a0 = ris_a;
        b0 = ris_b;
        // Counters are read mid-cycle, once the model has settled
        for (k = 0; k < 40000; k++) begin
            @(negedge core_clk);
            if (ris_a >= a0 + n && ris_b >= b0 + n) break;
        end
        check("rises", {31'h0, k < 40000}, 32'h1);
    endtask

    //****************************************************************
    // Scenarios
    //****************************************************************
    task automatic t_reset;
        check("out_a", {31'h0, out_a}, 32'h0);
        check("out_b", {31'h0, out_b}, 32'h0);
        check("oe_a", {31'h0, oe_a}, 32'h1);
        check("oe_b", {31'h0, oe_b}, 32'h1);
        rd(`FSPWM_ADDR_FAN_A, 32'h0);
        rd(`FSPWM_ADDR_FAN_B, 32'h0);
        rd(`FSPWM_ADDR_CTRL, 32'h50);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        wr(`FSPWM_ADDR_FAN_A, 32'hFFFF_FFAB);
        rd(`FSPWM_ADDR_FAN_A, 32'h0000_00AB);
        wr(`FSPWM_ADDR_CTRL, 32'h0000_00C3);
        rd(`FSPWM_ADDR_CTRL, 32'h0000_00C3);
        apb(12'h000, 1'b1, 32'h1, r, e);
        check("slverr_wr", {31'h0, e}, 32'h1);
        apb(12'h000, 1'b0, 32'h0, r, e);
        check("slverr_rd", {31'h0, e}, 32'h1);
        check("unmapped", r, 32'h0);
        wr(`FSPWM_ADDR_FAN_A, 32'h0);
    endtask

    // Fan b runs the mirror setting so swapped control bits show up
    task automatic t_freq;
        int i;
        int j;
        for (i = 0; i < 8; i++) begin
            j = 7 - i;
            wr(`FSPWM_ADDR_CTRL, {24'h0, 4'h5, j[1], i[1], j[2], i[2]});
            wr(`FSPWM_ADDR_FAN_A, {24'h0, i[0], 6'h3F, 1'b0});
            wr(`FSPWM_ADDR_FAN_B, {24'h0, j[0], 6'h05, 1'b0});
            wait_rises(3);
            check("period_a", per_a, 32'(64 * DV[i]));
            check("width_a", wid_a, 32'(63 * DV[i]));
            check("period_b", per_b, 32'(64 * DV[j]));
            check("width_b", wid_b, 32'(5 * DV[j]));
        end
    endtask

    task automatic t_levels;
        int lows;
        int highs;
        wr(`FSPWM_ADDR_FAN_A, 32'h0000_007F);
        wr(`FSPWM_ADDR_FAN_B, 32'h0000_0000);
        // Duty change may wait up to one full period
        repeat (6400) @(posedge core_clk);
        lows = 0;
        highs = 0;
        repeat (3200) begin
            @(negedge core_clk);
            lows += (out_a !== 1'b1 || oe_a !== 1'b1);
            highs += (out_b !== 1'b0 || oe_b !== 1'b1);
        end
        check("a_low_cycles", 32'(lows), 32'h0);
        check("b_high_cycles", 32'(highs), 32'h0);
        rd(`FSPWM_ADDR_STATUS, 32'h1);
    endtask

    // Hard reset in mid-run must drop a forced-high output
    task automatic t_hard_reset;
        wr(`FSPWM_ADDR_FAN_A, 32'h0000_0001);
        @(posedge core_clk);
        #1;
        check("ovr_a", {31'h0, out_a}, 32'h1);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check("rst_out_a", {31'h0, out_a}, 32'h0);
        check("rst_out_b", {31'h0, out_b}, 32'h0);
        check("rst_oe_a", {31'h0, oe_a}, 32'h1);
        rd(`FSPWM_ADDR_FAN_A, 32'h0);
        rd(`FSPWM_ADDR_STATUS, 32'h0);
    endtask

    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        sys_rst  = 1'b1;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset;
        t_regs;
        t_freq;
        t_levels;
        t_hard_reset;
        finish_test;
    end

    // Cuts a hang short well past the expected run length
    initial begin
        repeat (90000) @(posedge core_clk);
        n_errors++;
        finish_test;
    end
endmodule // fan_speed_pwm_control_tb
